// ### rtl/mep_bus_port.sv
/*
 * External bus and pin control: multiplexed address/data bus with latch
 * strobe, fetch/read/write/expander strobes, two quasi-bidirectional ports,
 * test, event, interrupt, single-step and standby pins.
 * Assumes a core that offers one transfer per machine cycle on op_* and
 * pins that are synchronous to clk.
 */
`include "mep_defines.svh"

module mep_bus_port (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire mep_pkg::mep_kind_type op_kind,
    input wire logic [11:0] op_addr,
    input wire logic [7:0] op_wdata,
    input wire logic op_last,
    output logic op_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic fetch_external,
    input wire logic halt_request,
    input wire logic p1_write,
    input wire logic p2_write,
    input wire logic [7:0] port_wdata,
    output logic [7:0] p1_level,
    output logic [7:0] p2_level,
    input wire logic clock_output_enable_instr,
    input wire logic start_counting_instr,
    input wire logic stop_counting_instr,
    output logic tpz_level,
    output logic eci_level,
    output logic timer_event,
    output logic ext_int_request,
    output logic halted,
    output logic standby_active,
    output logic address_latch_strobe,
    output logic program_fetch_strobe_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic expander_strobe_n,
    input wire logic [7:0] bus_data_lines_i,
    output logic [7:0] bus_data_lines_o,
    output logic bus_data_lines_oe,
    input wire logic [7:0] first_port_lines_i,
    output logic [7:0] first_port_lines_o,
    output logic [7:0] first_port_lines_oe,
    input wire logic [7:0] second_port_lines_i,
    output logic [7:0] second_port_lines_o,
    output logic [7:0] second_port_lines_oe,
    input wire logic test_pin_zero_i,
    output logic test_pin_zero_o,
    output logic test_pin_zero_oe,
    input wire logic event_count_input,
    input wire logic int_n,
    input wire logic external_fetch_force,
    input wire logic single_step_n,
    input wire logic standby_input_n
);

    typedef struct packed {
        logic [3:0] slot;
        mep_pkg::mep_kind_type kind;
        logic ext;
        logic [11:0] addr;
        logic [7:0] wdata;
        logic last;
        logic halt_pend;
        mep_pkg::mep_mode_type mode;
        logic [7:0] blatch;
        logic bdrv;
        logic [7:0] rdata;
        logic rvalid;
        logic tpz_en;
        logic tpz_lvl;
        logic cnt_en;
        logic eci_prev;
        logic evt;
        logic intr;
    } mep_state_type;

    mep_state_type st_q;
    mep_state_type st_d;

    logic run;
    logic cyc_end;
    logic step_stop;
    logic addr_kind;
    logic rd_kind;
    logic xfer_kind;
    logic [7:0] p2_ovr_en;
    logic [7:0] p2_ovr_oe;
    logic [7:0] p2_ovr_val;

    assign run = (st_q.mode == mep_pkg::MEP_RUN);
    assign cyc_end = (st_q.slot == `MEP_CYC_LAST);
    assign step_stop = st_q.last && !single_step_n;
    assign addr_kind = (st_q.kind == mep_pkg::MEP_FETCH && st_q.ext) ||
                       st_q.kind == mep_pkg::MEP_DRD || st_q.kind == mep_pkg::MEP_DWR;
    assign rd_kind = (st_q.kind == mep_pkg::MEP_FETCH && st_q.ext) ||
                     st_q.kind == mep_pkg::MEP_DRD || st_q.kind == mep_pkg::MEP_BIN;
    assign xfer_kind = st_q.kind == mep_pkg::MEP_XRD || st_q.kind == mep_pkg::MEP_XWR;

    // A new transfer is taken only at a cycle boundary that does not stop
    assign op_ready = run && cyc_end && !st_q.halt_pend && !step_stop && standby_input_n;

    always_comb
    begin
        st_d = st_q;
        st_d.rvalid = 1'b0;
        st_d.evt = 1'b0;
        st_d.tpz_lvl = test_pin_zero_i;
        st_d.intr = !int_n;
        st_d.eci_prev = event_count_input;
        if (clock_output_enable_instr)
        begin
            st_d.tpz_en = 1'b1;
        end
        if (start_counting_instr)
        begin
            st_d.cnt_en = 1'b1;
        end
        else if (stop_counting_instr)
        begin
            st_d.cnt_en = 1'b0;
        end
        // High-to-low edge on test pin one counts one event
        if (st_q.cnt_en && st_q.eci_prev && !event_count_input)
        begin
            st_d.evt = 1'b1;
        end
        if (halt_request)
        begin
            st_d.halt_pend = 1'b1;
        end
        if (!standby_input_n)
        begin
            // Standby left only through reset
            st_d.mode = mep_pkg::MEP_SLEEP;
            st_d.slot = `MEP_CYC_LAST;
            st_d.kind = mep_pkg::MEP_IDLE;
        end
        else
        begin
            unique case (st_q.mode)
                mep_pkg::MEP_RUN:
                begin
                    if (!cyc_end)
                    begin
                        st_d.slot = st_q.slot + 4'h1;
                    end
                    else if (st_q.halt_pend || halt_request)
                    begin
                        st_d.mode = mep_pkg::MEP_HALT;
                        st_d.halt_pend = 1'b0;
                        st_d.kind = mep_pkg::MEP_IDLE;
                    end
                    else if (step_stop)
                    begin
                        st_d.mode = mep_pkg::MEP_STEP;
                        st_d.kind = mep_pkg::MEP_IDLE;
                        st_d.last = 1'b0;
                    end
                    else
                    begin
                        st_d.slot = 4'h0;
                        st_d.kind = op_valid ? op_kind : mep_pkg::MEP_IDLE;
                        st_d.addr = op_addr;
                        st_d.wdata = op_wdata;
                        st_d.last = op_valid && op_last;
                        st_d.ext = external_fetch_force || (op_addr >= `MEP_ROM_LIMIT);
                    end
                end
                mep_pkg::MEP_HALT:
                begin
                    if (!int_n)
                    begin
                        st_d.mode = mep_pkg::MEP_RUN;
                    end
                end
                mep_pkg::MEP_STEP:
                begin
                    if (single_step_n)
                    begin
                        st_d.mode = mep_pkg::MEP_RUN;
                    end
                end
                mep_pkg::MEP_SLEEP:
                begin
                    st_d.mode = mep_pkg::MEP_SLEEP;
                end
            endcase
        end
        if (run && st_q.slot == `MEP_ADDR_OFF)
        begin
            if (st_q.kind == mep_pkg::MEP_BOUT)
            begin
                st_d.blatch = st_q.wdata;
                st_d.bdrv = 1'b1;
            end
            else if (st_q.kind == mep_pkg::MEP_BIN)
            begin
                st_d.bdrv = 1'b0;
            end
        end
        // Sample in the last strobe slot, while the source still drives
        if (run && st_q.slot == `MEP_SAMPLE)
        begin
            if (rd_kind)
            begin
                st_d.rdata = bus_data_lines_i;
                st_d.rvalid = 1'b1;
            end
            else if (st_q.kind == mep_pkg::MEP_XRD)
            begin
                st_d.rdata = {4'h0, second_port_lines_i[7:4]};
                st_d.rvalid = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
            st_q.slot <= `MEP_CYC_LAST;
            st_q.kind <= mep_pkg::MEP_IDLE;
            // Standby is entered while the standby input is held low and left only through reset
            st_q.mode <= standby_input_n ? mep_pkg::MEP_RUN : mep_pkg::MEP_SLEEP;
            st_q.eci_prev <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Strobes: latch strobe high in slots 1..3, others low in slots 6..12
    logic ale_win;
    logic stb_win;
    assign ale_win = run && st_q.slot >= `MEP_ALE_ON && st_q.slot < `MEP_ALE_OFF;
    assign stb_win = run && st_q.slot >= `MEP_STB_ON && st_q.slot < `MEP_STB_OFF;

    assign address_latch_strobe = ale_win;
    assign program_fetch_strobe_n = !(stb_win && st_q.kind == mep_pkg::MEP_FETCH && st_q.ext);
    assign read_strobe_n = !(stb_win && (st_q.kind == mep_pkg::MEP_DRD ||
                                         st_q.kind == mep_pkg::MEP_BIN));
    assign write_strobe_n = !(stb_win && (st_q.kind == mep_pkg::MEP_DWR ||
                                          st_q.kind == mep_pkg::MEP_BOUT));
    assign expander_strobe_n = !(stb_win && xfer_kind);

    always_comb
    begin
        bus_data_lines_o = st_q.blatch;
        bus_data_lines_oe = st_q.bdrv;
        if (run && addr_kind && st_q.slot < `MEP_ADDR_OFF)
        begin
            bus_data_lines_o = st_q.addr[7:0];
            bus_data_lines_oe = 1'b1;
        end
        else if (run && st_q.kind == mep_pkg::MEP_DWR)
        begin
            bus_data_lines_o = st_q.wdata;
            bus_data_lines_oe = 1'b1;
        end
        else if (run && rd_kind)
        begin
            // Float a slot ahead of the read so nobody fights the source
            bus_data_lines_oe = 1'b0;
        end
    end

    always_comb
    begin
        p2_ovr_en = 8'h00;
        p2_ovr_oe = 8'h00;
        p2_ovr_val = 8'h00;
        if (run && st_q.kind == mep_pkg::MEP_FETCH && st_q.ext && st_q.slot < `MEP_STB_OFF)
        begin
            p2_ovr_en[3:0] = 4'hF;
            p2_ovr_oe[3:0] = 4'hF;
            p2_ovr_val[3:0] = st_q.addr[11:8];
        end
        if (run && xfer_kind)
        begin
            p2_ovr_en[7:4] = 4'hF;
            if (st_q.slot < `MEP_STB_ON)
            begin
                p2_ovr_oe[7:4] = 4'hF;
                p2_ovr_val[7:4] = st_q.addr[3:0];
            end
            else if (st_q.kind == mep_pkg::MEP_XWR)
            begin
                p2_ovr_oe[7:4] = 4'hF;
                p2_ovr_val[7:4] = st_q.wdata[3:0];
            end
            else
            begin
                p2_ovr_val[7:4] = 4'hF;
            end
        end
    end

    mep_qport #(.W(8)) u_port1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_stb(p1_write),
        .wr_data(port_wdata),
        .ovr_en(8'h00),
        .ovr_oe(8'h00),
        .ovr_val(8'h00),
        .pin_i(first_port_lines_i),
        .pin_o(first_port_lines_o),
        .pin_oe(first_port_lines_oe),
        .pin_level(p1_level)
    );

    mep_qport #(.W(8)) u_port2 (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_stb(p2_write),
        .wr_data(port_wdata),
        .ovr_en(p2_ovr_en),
        .ovr_oe(p2_ovr_oe),
        .ovr_val(p2_ovr_val),
        .pin_i(second_port_lines_i),
        .pin_o(second_port_lines_o),
        .pin_oe(second_port_lines_oe),
        .pin_level(p2_level)
    );

    // Machine-rate clock out; slot MSB gives one period per cycle
    assign test_pin_zero_o = st_q.slot[3];
    assign test_pin_zero_oe = st_q.tpz_en;
    assign tpz_level = st_q.tpz_lvl;
    assign eci_level = st_q.eci_prev;
    assign timer_event = st_q.evt;
    assign ext_int_request = st_q.intr;
    assign rd_data = st_q.rdata;
    assign rd_valid = st_q.rvalid;
    assign fetch_external = st_q.ext;
    assign halted = (st_q.mode == mep_pkg::MEP_HALT) || (st_q.mode == mep_pkg::MEP_STEP);
    assign standby_active = (st_q.mode == mep_pkg::MEP_SLEEP);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_ale_width;
        $rose(address_latch_strobe) |-> address_latch_strobe[*3] ##1 !address_latch_strobe;
    endproperty
    a_ale_width: assert property (p_ale_width)
        else $error("latch strobe width wrong");

    property p_ale_once;
        $rose(address_latch_strobe) |=> (!$rose(address_latch_strobe))[*8];
    endproperty
    a_ale_once: assert property (p_ale_once)
        else $error("second latch strobe in one cycle");

    property p_strobe_order;
        ($fell(read_strobe_n) || $fell(write_strobe_n) || $fell(program_fetch_strobe_n) ||
         $fell(expander_strobe_n)) |-> !address_latch_strobe && $past(!address_latch_strobe, 2);
    endproperty
    a_strobe_order: assert property (p_strobe_order)
        else $error("strobe began during latch strobe");

    property p_strobe_end;
        $rose(address_latch_strobe) |-> read_strobe_n && write_strobe_n &&
            program_fetch_strobe_n && expander_strobe_n && $past(read_strobe_n);
    endproperty
    a_strobe_end: assert property (p_strobe_end)
        else $error("strobe still low at latch strobe");

    property p_rd_float;
        !read_strobe_n || !program_fetch_strobe_n |-> !bus_data_lines_oe && $past(!bus_data_lines_oe);
    endproperty
    a_rd_float: assert property (p_rd_float)
        else $error("bus driven during read strobe");

    property p_fetch_addr;
        $rose(address_latch_strobe) && st_q.kind == mep_pkg::MEP_FETCH && st_q.ext |->
            bus_data_lines_oe && bus_data_lines_o == st_q.addr[7:0] &&
            second_port_lines_o[3:0] == st_q.addr[11:8] && second_port_lines_oe[3:0] == 4'hF;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr)
        else $error("fetch address missing on bus");

    property p_wr_data;
        $fell(write_strobe_n) |-> (bus_data_lines_oe && bus_data_lines_o == st_q.wdata)[*7];
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("write data not stable");

    property p_halt_quiet;
        halted || standby_active |-> !address_latch_strobe && read_strobe_n && write_strobe_n &&
            program_fetch_strobe_n && expander_strobe_n;
    endproperty
    a_halt_quiet: assert property (p_halt_quiet)
        else $error("strobe active while stopped");

    property p_event;
        timer_event |-> $past(st_q.cnt_en) && $past(!event_count_input) && $past(event_count_input, 2);
    endproperty
    a_event: assert property (p_event)
        else $error("event without enabled edge");

    property p_rd_data;
        $rose(read_strobe_n) && st_q.kind == mep_pkg::MEP_DRD |-> rd_valid && rd_data == $past(bus_data_lines_i);
    endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("read byte not returned");

endmodule : mep_bus_port

// ### common/mep_defines.svh
/*
 * Slot timing, address limits and reset values for the external bus port.
 * Assumes one machine cycle of fifteen clock slots; included by bare name.
 */
`ifndef MEP_DEFINES_SVH
`define MEP_DEFINES_SVH

// Slot positions inside one machine cycle
`define MEP_CYC_LAST 4'hE
`define MEP_ALE_ON 4'h1
`define MEP_ALE_OFF 4'h4
`define MEP_ADDR_OFF 4'h5
`define MEP_STB_ON 4'h6
`define MEP_STB_OFF 4'hD
`define MEP_SAMPLE 4'hC

// First address that lies above the internal program memory (2048)
`define MEP_ROM_LIMIT 12'h800

// Port output latch after reset: all ones, so pins read as inputs
`define MEP_PORT_RST 8'hFF

`endif

// ### common/mep_pkg.sv
/*
 * Types shared by the external bus port: transfer kinds and run modes.
 * Assumes no other package; users write mep_pkg::name.
 */
package mep_pkg;

    typedef enum logic [2:0] {
        MEP_IDLE = 3'h0,
        MEP_FETCH = 3'h1,
        MEP_DRD = 3'h2,
        MEP_DWR = 3'h3,
        MEP_BIN = 3'h4,
        MEP_BOUT = 3'h5,
        MEP_XRD = 3'h6,
        MEP_XWR = 3'h7
    } mep_kind_type;

    typedef enum logic [1:0] {
        MEP_RUN = 2'h0,
        MEP_HALT = 2'h1,
        MEP_STEP = 2'h2,
        MEP_SLEEP = 2'h3
    } mep_mode_type;

endpackage : mep_pkg

// ### rtl/mep_qport.sv
/*
 * Quasi-bidirectional port: output latch, weak-high pins, per-bit override.
 * Assumes an external pull-up on each pin; pins drive only lows unless overridden.
 */
`include "mep_defines.svh"

module mep_qport #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr_stb,
    input wire logic [W-1:0] wr_data,
    input wire logic [W-1:0] ovr_en,
    input wire logic [W-1:0] ovr_oe,
    input wire logic [W-1:0] ovr_val,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] pin_o,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] pin_level
);

    typedef struct packed {
        logic [W-1:0] latch;
        logic [W-1:0] level;
    } mep_qstate_type;

    mep_qstate_type st_q;
    mep_qstate_type st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.level = pin_i;
        if (wr_stb)
        begin
            st_d.latch = wr_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            // Latch comes up as ones, so the port reads as input at once
            st_q.latch <= W'(`MEP_PORT_RST);
            st_q.level <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // A one bit is only pulled high, so an outside driver may pull it low
    assign pin_o = (ovr_en & ovr_val) | (~ovr_en & st_q.latch);
    assign pin_oe = (ovr_en & ovr_oe) | (~ovr_en & ~st_q.latch);
    assign pin_level = st_q.level;

endmodule : mep_qport

// ### testbench/mep_ext_mem.sv
/*
 * Far-side model: external program and data memory on the multiplexed bus.
 * Assumes the bench feeds bus_i to the device; the bus has no pull-up.
 */
module mep_ext_mem (
    input wire logic clk,
    input wire logic address_latch_strobe,
    input wire logic program_fetch_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] bus_o,
    input wire logic bus_oe,
    output logic [7:0] bus_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [256];
    logic [7:0] lat;
    logic [7:0] last;

    always_ff @(posedge clk)
    begin
        if (address_latch_strobe)
            lat <= bus_i;
        if (!write_strobe_n)
            mem[lat] <= bus_i;
        last <= bus_i;
    end

    // Released bus flips each cycle so a stale byte cannot pass
    always_comb
    begin
        if (bus_oe)
            bus_i = bus_o;
        else if (!program_fetch_strobe_n)
            bus_i = lat ^ 8'hA5;
        else if (!read_strobe_n)
            bus_i = mem[lat];
        else
            bus_i = ~last;
    end
endmodule : mep_ext_mem

// ### testbench/testbench.sv
/*
 * Self-checking bench: bus transfers, ports, test pins, halt, step, standby.
 * Assumes pulled-up port pins and the far-side memory model on the bus.
 */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, op_last = 1'b0, halt_request = 1'b0;
    logic p1_write = 1'b0, p2_write = 1'b0, clock_output_enable_instr = 1'b0, start_counting_instr = 1'b0;
    logic stop_counting_instr = 1'b0, event_count_input = 1'b1, int_n = 1'b1, external_fetch_force = 1'b0;
    logic single_step_n = 1'b1, standby_input_n = 1'b1, tpz_ext = 1'b1;
    mep_pkg::mep_kind_type op_kind = mep_pkg::MEP_IDLE;
    logic [11:0] op_addr = 12'h000;
    logic [7:0] op_wdata = 8'h00, port_wdata = 8'h00, p1_ext = 8'hFF;
    logic op_ready, rd_valid, fetch_external, halted, standby_active, tpz_level, eci_level, timer_event;
    logic ext_int_request, address_latch_strobe, program_fetch_strobe_n, read_strobe_n, write_strobe_n;
    logic expander_strobe_n, bus_data_lines_oe, test_pin_zero_i, test_pin_zero_o, test_pin_zero_oe;
    logic [7:0] rd_data, p1_level, p2_level, bus_data_lines_i, bus_data_lines_o;
    logic [7:0] first_port_lines_i, first_port_lines_o, first_port_lines_oe;
    logic [7:0] second_port_lines_i, second_port_lines_o, second_port_lines_oe;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    always #10 clk = ~clk;
    // Pull-ups on released port pins; bench may pull port one low
    assign first_port_lines_i = (first_port_lines_o | ~first_port_lines_oe) & p1_ext;
    assign second_port_lines_i = second_port_lines_o | ~second_port_lines_oe;
    assign test_pin_zero_i = test_pin_zero_oe ? test_pin_zero_o : tpz_ext;

    mep_bus_port uut (.clk, .sys_rst, .op_valid, .op_kind, .op_addr, .op_wdata, .op_last, .op_ready, .rd_data,
        .rd_valid, .fetch_external, .halt_request, .p1_write, .p2_write, .port_wdata, .p1_level, .p2_level,
        .clock_output_enable_instr, .start_counting_instr, .stop_counting_instr, .tpz_level, .eci_level,
        .timer_event, .ext_int_request, .halted, .standby_active, .address_latch_strobe, .program_fetch_strobe_n,
        .read_strobe_n, .write_strobe_n, .expander_strobe_n, .bus_data_lines_i, .bus_data_lines_o,
        .bus_data_lines_oe, .first_port_lines_i, .first_port_lines_o, .first_port_lines_oe, .second_port_lines_i,
        .second_port_lines_o, .second_port_lines_oe, .test_pin_zero_i, .test_pin_zero_o, .test_pin_zero_oe,
        .event_count_input, .int_n, .external_fetch_force, .single_step_n, .standby_input_n);
    mep_ext_mem far_side (.clk, .address_latch_strobe, .program_fetch_strobe_n, .read_strobe_n,
        .write_strobe_n, .bus_o(bus_data_lines_o), .bus_oe(bus_data_lines_oe), .bus_i(bus_data_lines_i));

    task automatic stop_test;
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_idle(input logic ale);
        chk({3'h0, address_latch_strobe, program_fetch_strobe_n, read_strobe_n, write_strobe_n,
            expander_strobe_n}, {3'h0, ale, 4'hF});
    endtask : chk_idle

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wait_for(ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim && s !== v; i++)
            tick(1);
        chk({7'h00, s}, {7'h00, v});
    endtask : wait_for

    // Strobe mask order: fetch, read, write, expander
    task automatic run_op(input logic [2:0] k, input logic [11:0] a, input logic [7:0] wd, input logic [3:0] sm,
        input logic [7:0] exp_rd, input logic use_rd);
        logic [3:0] seen;
        logic [7:0] got;
        logic prev;
        logic adr;
        int ales;
        seen = 4'h0;
        got = 8'h00;
        prev = 1'b0;
        ales = 0;
        adr = k == 3'h2 || k == 3'h3 || (k == 3'h1 && sm[3]);
        @(posedge clk);
        op_valid <= 1'b1;
        op_kind <= mep_pkg::mep_kind_type'(k);
        op_addr <= a;
        op_wdata <= wd;
        #1;
        for (int i = 0; i < 40 && op_ready !== 1'b1; i++)
            tick(1);
        @(posedge clk);
        op_valid <= 1'b0;
        for (int i = 0; i < 15; i++)
        begin
            #1;
            ales += int'(address_latch_strobe && !prev);
            prev = address_latch_strobe;
            seen |= ~{program_fetch_strobe_n, read_strobe_n, write_strobe_n, expander_strobe_n};
            if (i == 0 && k == 3'h1)
                chk({7'h00, fetch_external}, {7'h00, sm[3]});
            if (address_latch_strobe && adr)
                chk(bus_data_lines_o & {8{bus_data_lines_oe}}, a[7:0]);
            if (address_latch_strobe && adr && k == 3'h1)
                chk({4'h0, second_port_lines_o[3:0]}, {4'h0, a[11:8]});
            if (address_latch_strobe)
                chk_idle(1'b1);
            if (!read_strobe_n)
                chk({7'h00, bus_data_lines_oe}, 8'h00);
            if (k == 3'h7 && !expander_strobe_n)
                chk({4'h0, second_port_lines_o[7:4]}, {4'h0, wd[3:0]});
            if (rd_valid === 1'b1)
                got = rd_data;
            @(posedge clk);
        end
        chk(8'(ales), 8'h01);
        chk({4'h0, seen}, {4'h0, sm});
        if (use_rd)
            chk(got, exp_rd);
    endtask : run_op

    task automatic ports_test;
        @(posedge clk);
        p1_ext <= 8'h3C;
        tick(3);
        chk(p1_level, 8'h3C);
        chk(p2_level, 8'hFF);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            port_wdata <= i ? 8'hFF : 8'h00;
            p1_write <= 1'b1;
            @(posedge clk);
            p1_write <= 1'b0;
            tick(3);
            chk(p1_level, i ? 8'h3C : 8'h00);
        end
    endtask : ports_test

    task automatic bus_test;
        @(posedge clk);
        external_fetch_force <= 1'b1;
        run_op(3'h1, 12'h3C5, 8'h00, 4'h8, 8'h60, 1'b1);
        @(posedge clk);
        external_fetch_force <= 1'b0;
        run_op(3'h1, 12'h3C5, 8'h00, 4'h0, 8'h00, 1'b0);
        run_op(3'h1, 12'h9A7, 8'h00, 4'h8, 8'h02, 1'b1);
        run_op(3'h3, 12'h05A, 8'h3E, 4'h2, 8'h00, 1'b0);
        run_op(3'h2, 12'h05A, 8'h00, 4'h4, 8'h3E, 1'b1);
        run_op(3'h5, 12'h000, 8'hC3, 4'h2, 8'h00, 1'b0);
        tick(15);
        chk(bus_data_lines_o & {8{bus_data_lines_oe}}, 8'hC3);
        run_op(3'h4, 12'h000, 8'h00, 4'h4, 8'h00, 1'b0);
        run_op(3'h7, 12'h006, 8'h09, 4'h1, 8'h00, 1'b0);
        run_op(3'h6, 12'h006, 8'h00, 4'h1, 8'h0F, 1'b1);
    endtask : bus_test

    task automatic pins_test;
        logic v;
        int n;
        @(posedge clk);
        tpz_ext <= 1'b0;
        tick(3);
        chk({7'h00, tpz_level}, 8'h00);
        @(posedge clk);
        clock_output_enable_instr <= 1'b1;
        @(posedge clk);
        clock_output_enable_instr <= 1'b0;
        tick(3);
        chk({7'h00, test_pin_zero_oe}, 8'h01);
        v = test_pin_zero_o;
        n = 0;
        repeat (30)
        begin
            tick(1);
            n += int'(test_pin_zero_o !== v);
            v = test_pin_zero_o;
        end
        chk({7'h00, n > 1}, 8'h01);
        @(posedge clk);
        start_counting_instr <= 1'b1;
        @(posedge clk);
        start_counting_instr <= 1'b0;
        event_count_input <= 1'b0;
        wait_for(timer_event, 1'b1, 6);
        @(posedge clk);
        event_count_input <= 1'b1;
        stop_counting_instr <= 1'b1;
        @(posedge clk);
        stop_counting_instr <= 1'b0;
        event_count_input <= 1'b0;
        n = 0;
        repeat (6)
        begin
            tick(1);
            n += int'(timer_event !== 1'b0);
        end
        chk(8'(n), 8'h00);
        chk({7'h00, eci_level}, 8'h00);
    endtask : pins_test

    task automatic halt_test;
        @(posedge clk);
        halt_request <= 1'b1;
        @(posedge clk);
        halt_request <= 1'b0;
        wait_for(halted, 1'b1, 20);
        repeat (15)
        begin
            tick(1);
            chk_idle(1'b0);
        end
        @(posedge clk);
        int_n <= 1'b0;
        tick(2);
        chk({7'h00, ext_int_request}, 8'h01);
        wait_for(halted, 1'b0, 40);
        @(posedge clk);
        int_n <= 1'b1;
        single_step_n <= 1'b0;
        op_last <= 1'b1;
        run_op(3'h1, 12'h123, 8'h00, 4'h0, 8'h00, 1'b0);
        wait_for(halted, 1'b1, 20);
        tick(1);
        chk_idle(1'b0);
        @(posedge clk);
        single_step_n <= 1'b1;
        op_last <= 1'b0;
        wait_for(halted, 1'b0, 40);
    endtask : halt_test

    task automatic standby_test;
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        standby_input_n <= 1'b0;
        tick(3);
        chk({7'h00, standby_active}, 8'h01);
        chk_idle(1'b0);
        @(posedge clk);
        standby_input_n <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        tick(2);
        chk({7'h00, standby_active}, 8'h00);
        run_op(3'h1, 12'h9A7, 8'h00, 4'h8, 8'h02, 1'b1);
    endtask : standby_test

    // Whole run needs about 500 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            stop_test;
        end
    end

    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        tick(1);
        chk_idle(1'b0);
        chk(first_port_lines_oe, 8'h00);
        ports_test;
        bus_test;
        pins_test;
        halt_test;
        standby_test;
        stop_test;
    end
endmodule : testbench
